// [core/shb_host_port.sv]
// host bus port, daisy chain and modem control pins
module shb_host_port
  import shb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       chip_sel_n,
  input  wire logic       chan_sel,
  input  wire logic       data_ctl_sel,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       vector_ack_n,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe_n,
  input  wire logic       chain_priority_in,
  output logic            chain_priority_out,
  output logic            irq_out,
  output logic            irq_oe_n,
  input  wire logic       send_permit_a_n,
  input  wire logic       send_permit_b_n,
  input  wire logic       carrier_present_a_n,
  input  wire logic       carrier_present_b_n,
  output logic            terminal_ready_or_dma_req_a,
  output logic            terminal_ready_or_dma_req_b,
  input  wire logic [7:0] vector_value,
  input  wire logic       int_ack_done,
  input  shb_chan_cfg_t   cfg_a,
  input  shb_chan_cfg_t   cfg_b,
  input  wire logic [1:0] dma_want,
  output logic      [1:0] tx_enable,
  output logic      [1:0] rx_enable,
  output shb_chan_stat_t  stat_a,
  output shb_chan_stat_t  stat_b,
  output logic            soft_reset,
  output logic            under_service_flag,
  output logic            wr_strobe,
  output logic            wr_chan_a,
  output logic            wr_is_data,
  output logic      [7:0] wr_byte
);
  // two-stage synchronisers for every pin input
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  wire  [NSYNC-1:0] pin_raw = {host_data_in, chip_sel_n, chan_sel, data_ctl_sel, rd_n, wr_n,
                               vector_ack_n, chain_priority_in};
  logic [3:0]       mdm1;
  logic [3:0]       mdm2;
  logic [3:0]       mdm_prev;
  wire  [3:0]       mdm_raw = {carrier_present_b_n, send_permit_b_n, carrier_present_a_n, send_permit_a_n};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= {NSYNC{1'b1}};
      sync2 <= {NSYNC{1'b1}};
      mdm1  <= 4'hF;
      mdm2  <= 4'hF;
    end else if (clk_en) begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      mdm1  <= mdm_raw;
      mdm2  <= mdm1;
    end
  end

  wire [7:0] s_data   = sync2[14:7];
  wire       s_cs_n   = sync2[6];
  wire       s_chan   = sync2[5];
  wire       s_dc     = sync2[4];
  wire       s_rd_n   = sync2[3];
  wire       s_wr_n   = sync2[2];
  wire       s_ack_n  = sync2[1];
  wire       s_iei    = sync2[0];

  // bus decode
  wire selected   = !s_cs_n;
  wire both_low   = !s_rd_n && !s_wr_n;
  wire do_reset   = both_low;
  wire do_read    = selected && !s_rd_n && s_wr_n && s_ack_n;
  wire do_write   = selected && !s_wr_n && s_rd_n;
  wire ack_read   = !s_ack_n && !s_rd_n && s_wr_n;
  wire chan_is_a  = s_chan;
  wire is_data    = s_dc;

  shb_state_t state;
  shb_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (do_reset) begin
          next_state = ST_RESET;
        end else if (do_write) begin
          next_state = ST_WRITE;
        end else if (do_read || ack_read) begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        if (do_reset) begin
          next_state = ST_RESET;
        end else if (s_rd_n || (s_cs_n && s_ack_n)) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (do_reset) begin
          next_state = ST_RESET;
        end else if (s_wr_n || s_cs_n) begin
          next_state = ST_IDLE;
        end
      end
      ST_RESET: begin
        if (s_rd_n || s_wr_n) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // write takes effect once per strobe, on entry
  wire write_start = (state == ST_IDLE) && !do_reset && do_write;
  wire read_start  = (state == ST_IDLE) && !do_reset && do_read;
  wire ack_start   = (state == ST_IDLE) && !do_reset && !do_write && ack_read;

  // storage: index = {channel, data/control}
  logic [1:0] waddr;
  logic [1:0] raddr;
  logic [7:0] mem_rdata;
  assign waddr = {!chan_is_a, is_data};
  assign raddr = {!chan_is_a, is_data};

  shb_regmem #(.WIDTH(8), .DEPTH(REG_DEPTH)) u_mem (
    .clk   (clk),
    .ce    (clk_en),
    .we    (write_start),
    .waddr (waddr),
    .wdata (s_data),
    .raddr (raddr),
    .rdata (mem_rdata)
  );

  // interrupt pending from modem edges
  wire [3:0] mdm_edge = mdm2 ^ mdm_prev;
  wire [3:0] ie_mask  = {cfg_b.ie_carrier, cfg_b.ie_send, cfg_a.ie_carrier, cfg_a.ie_send};
  logic [3:0] change;
  logic       ack_latched;
  logic       ack_is_ours;
  wire        pending   = |(change & ie_mask);
  // chain may take acknowledge only when higher devices idle
  wire        may_ack   = s_iei && pending && !under_service_flag;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state              <= ST_IDLE;
      mdm_prev           <= 4'hF;
      change             <= 4'h0;
      ack_latched        <= 1'b0;
      ack_is_ours        <= 1'b0;
      under_service_flag <= 1'b0;
      soft_reset         <= 1'b0;
    end else if (clk_en) begin
      state       <= next_state;
      soft_reset  <= do_reset;
      mdm_prev    <= mdm2;
      ack_latched <= !s_ack_n;
      // edges set flags; a set beats a same-cycle command-write clear, but a soft reset clears all flags
      if (do_reset) begin
        change <= 4'h0;
      end else if (write_start && !is_data) begin
        change <= mdm_edge | (change & ~{!chan_is_a, !chan_is_a, chan_is_a, chan_is_a});
      end else begin
        change <= change | mdm_edge;
      end
      if (ack_start) begin
        ack_is_ours <= may_ack;
      end else if (s_ack_n) begin
        ack_is_ours <= 1'b0;
      end
      // a new acknowledge beats a same-cycle service-done clear
      if (do_reset) begin
        under_service_flag <= 1'b0;
      end else if (ack_start && may_ack) begin
        under_service_flag <= 1'b1;
      end else if (int_ack_done) begin
        under_service_flag <= 1'b0;
      end
    end
  end

  // bus drivers and pin outputs
  logic        rd_phase;
  logic        rd_vec;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_phase                    <= 1'b0;
      rd_vec                      <= 1'b0;
      host_data_out               <= BUS_IDLE;
      host_data_oe_n              <= 1'b1;
      chain_priority_out          <= 1'b0;
      irq_out                     <= 1'b0;
      irq_oe_n                    <= 1'b1;
      terminal_ready_or_dma_req_a <= 1'b0;
      terminal_ready_or_dma_req_b <= 1'b0;
      tx_enable                   <= 2'b00;
      rx_enable                   <= 2'b00;
      stat_a                      <= '0;
      stat_b                      <= '0;
      wr_strobe                   <= 1'b0;
      wr_chan_a                   <= 1'b0;
      wr_is_data                  <= 1'b0;
      wr_byte                     <= 8'h00;
    end else if (clk_en) begin
      rd_phase <= (next_state == ST_READ) && read_start;
      rd_vec   <= ack_start && may_ack;
      if (rd_phase) begin
        host_data_out  <= mem_rdata;
        host_data_oe_n <= 1'b0;
      end else if (rd_vec) begin
        host_data_out  <= vector_value;
        host_data_oe_n <= 1'b0;
      end else if (state != ST_READ || next_state != ST_READ) begin
        host_data_oe_n <= 1'b1;
      end
      // blocks lower devices while acknowledging or under service
      chain_priority_out <= s_iei && !under_service_flag && !(ack_latched && pending);
      irq_out            <= 1'b0;
      irq_oe_n           <= !(pending && !under_service_flag);
      terminal_ready_or_dma_req_a <= cfg_a.dma_mode ? dma_want[CH_A] : cfg_a.ready_bit;
      terminal_ready_or_dma_req_b <= cfg_b.dma_mode ? dma_want[CH_B] : cfg_b.ready_bit;
      tx_enable[CH_A] <= !cfg_a.auto_en || !mdm2[0];
      tx_enable[CH_B] <= !cfg_b.auto_en || !mdm2[2];
      rx_enable[CH_A] <= !cfg_a.auto_en || !mdm2[1];
      rx_enable[CH_B] <= !cfg_b.auto_en || !mdm2[3];
      stat_a <= '{send_level: !mdm2[0], carrier_level: !mdm2[1], send_change: change[0], carrier_change: change[1]};
      stat_b <= '{send_level: !mdm2[2], carrier_level: !mdm2[3], send_change: change[2], carrier_change: change[3]};
      wr_strobe  <= write_start;
      wr_chan_a  <= chan_is_a;
      wr_is_data <= is_data;
      wr_byte    <= s_data;
    end
  end
endmodule

// [core/shb_pkg.sv]
// package for the host bus and modem pin block
package shb_pkg;
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam logic [7:0] VECTOR_RESET = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  localparam int RESET_HOLD_CYCLES = 2;
  localparam int REG_DEPTH = 4;

  typedef struct packed {
    logic sel_a;
    logic is_data;
    logic rd;
    logic wr;
  } shb_access_t;

  typedef struct packed {
    logic auto_en;
    logic dma_mode;
    logic ready_bit;
    logic ie_send;
    logic ie_carrier;
  } shb_chan_cfg_t;

  typedef struct packed {
    logic send_level;
    logic carrier_level;
    logic send_change;
    logic carrier_change;
  } shb_chan_stat_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_READ   = 2'b01,
    ST_WRITE  = 2'b10,
    ST_RESET  = 2'b11
  } shb_state_t;
endpackage

// [core/shb_regmem.sv]
// per-channel data/control storage, registered read data
module shb_regmem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk,
  input  wire logic                     ce,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// [testbench/shb_host_model.sv]
// host side bus wire: host drive, device drive, floating
module shb_host_model
  import shb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] dev_data,
  input  wire logic       dev_oe_n,
  input  wire logic       host_en,
  input  wire logic [7:0] host_byte,
  output logic      [7:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last = BUS_IDLE;
  always_ff @(posedge clk) begin
    last <= bus;
  end
  // host holds data for whole strobe, released bus flips
  assign bus = !dev_oe_n ? dev_data : host_en ? host_byte : ~last;
endmodule

// [testbench/shb_host_port_properties.sv]
// timing relations at the host port pins
module shb_host_port_properties
  import shb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       chip_sel_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       vector_ack_n,
  input  wire logic       chain_priority_in,
  input  wire logic       send_permit_a_n,
  input  wire logic       carrier_present_b_n,
  input  shb_chan_cfg_t   cfg_a,
  input  shb_chan_cfg_t   cfg_b,
  input  wire logic [1:0] dma_want,
  input  wire logic       host_data_oe_n,
  input  wire logic       chain_priority_out,
  input  wire logic       irq_out,
  input  wire logic [1:0] tx_enable,
  input  wire logic [1:0] rx_enable,
  input  wire logic       soft_reset,
  input  wire logic       wr_strobe,
  input  wire logic       terminal_ready_or_dma_req_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_released; (chip_sel_n && vector_ack_n)[*5] |-> host_data_oe_n; endproperty
  property p_read; (!chip_sel_n && !rd_n && wr_n && vector_ack_n)[*6] |-> !host_data_oe_n; endproperty
  property p_wr_once; wr_strobe |=> !wr_strobe; endproperty
  property p_wr_cause; wr_strobe |-> $past(!chip_sel_n && !wr_n && rd_n, 3); endproperty
  property p_rst_cmd; (!rd_n && !wr_n)[*5] |-> soft_reset; endproperty
  property p_no_xfer; soft_reset |-> !wr_strobe; endproperty
  property p_chain; (!chain_priority_in)[*4] |-> !chain_priority_out; endproperty
  property p_irq_pin; irq_out == 1'h0; endproperty
  property p_tx; (cfg_a.auto_en && !send_permit_a_n)[*5] |-> tx_enable[0]; endproperty
  property p_rx; (cfg_b.auto_en && !carrier_present_b_n)[*5] |-> rx_enable[1]; endproperty
  property p_req; (cfg_b.dma_mode && dma_want[1])[*2] |-> terminal_ready_or_dma_req_b; endproperty
  a_released: assert property (p_released) else $error("bus driven while idle");
  a_read: assert property (p_read) else $error("read not driving bus");
  a_wr_once: assert property (p_wr_once) else $error("write strobe too long");
  a_wr_cause: assert property (p_wr_cause) else $error("write strobe without write");
  a_rst_cmd: assert property (p_rst_cmd) else $error("no soft reset");
  a_no_xfer: assert property (p_no_xfer) else $error("transfer during reset");
  a_chain: assert property (p_chain) else $error("chain out while blocked");
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin driven high");
  a_tx: assert property (p_tx) else $error("transmitter not enabled");
  a_rx: assert property (p_rx) else $error("receiver not enabled");
  a_req: assert property (p_req) else $error("no dma request");
  c_write: cover property (wr_strobe);
  c_reset: cover property (soft_reset);
  c_vector: cover property (!host_data_oe_n && !vector_ack_n);
endmodule
bind shb_host_port shb_host_port_properties shb_host_port_properties_inst (.clk, .rst_n, .chip_sel_n, .rd_n, .wr_n,
  .vector_ack_n, .chain_priority_in, .send_permit_a_n, .carrier_present_b_n, .cfg_a, .cfg_b, .dma_want,
  .host_data_oe_n, .chain_priority_out, .irq_out, .tx_enable, .rx_enable, .soft_reset, .wr_strobe,
  .terminal_ready_or_dma_req_b);

// [testbench/shb_host_port_tb.sv]
// testbench of the host port block
module shb_host_port_tb import shb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, clk_en, chip_sel_n, chan_sel, data_ctl_sel, rd_n, wr_n, vector_ack_n, int_ack_done, host_en;
  logic chain_priority_in, send_permit_a_n, send_permit_b_n, carrier_present_a_n, carrier_present_b_n;
  logic [7:0] host_data_out, vector_value, host_byte, bus, wr_byte;
  logic host_data_oe_n, chain_priority_out, irq_out, irq_oe_n, terminal_ready_or_dma_req_a;
  logic terminal_ready_or_dma_req_b, soft_reset, under_service_flag, wr_strobe, wr_chan_a, wr_is_data;
  logic [1:0] dma_want, tx_enable, rx_enable;
  shb_chan_cfg_t cfg_a, cfg_b;
  shb_chan_stat_t stat_a, stat_b;
  int num_errors = 0, n_tests = 0, nstb = 0, k, s;
  shb_host_port shb_host_port_inst (.clk, .rst_n, .clk_en, .chip_sel_n, .chan_sel, .data_ctl_sel, .rd_n, .wr_n,
    .vector_ack_n, .host_data_in(bus), .host_data_out, .host_data_oe_n, .chain_priority_in, .chain_priority_out,
    .irq_out, .irq_oe_n, .send_permit_a_n, .send_permit_b_n, .carrier_present_a_n, .carrier_present_b_n,
    .terminal_ready_or_dma_req_a, .terminal_ready_or_dma_req_b, .vector_value, .int_ack_done, .cfg_a, .cfg_b,
    .dma_want, .tx_enable, .rx_enable, .stat_a, .stat_b, .soft_reset, .under_service_flag, .wr_strobe, .wr_chan_a,
    .wr_is_data, .wr_byte);
  shb_host_model shb_host_model_inst (.clk, .dev_data(host_data_out), .dev_oe_n(host_data_oe_n), .host_en,
    .host_byte, .bus);
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (wr_strobe === 1'h1) nstb++;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic a, input logic d, input logic [7:0] b);
    @(posedge clk);
    {chip_sel_n, wr_n, host_en, chan_sel, data_ctl_sel, host_byte} <= {1'h0, 1'h0, 1'h1, a, d, b};
    for (k = 0; k < 8 && wr_strobe !== 1'h1; k++) begin @(posedge clk); #1; end
    chk("wr_strobe", wr_strobe, 8'h01);
    chk("wr_chan", wr_chan_a, a);
    chk("wr_dc", wr_is_data, d);
    chk("wr_byte", wr_byte, b);
    @(posedge clk);
    {chip_sel_n, wr_n, host_en} <= 3'h6;
    repeat (4) @(posedge clk);
  endtask
  task automatic bus_rd(input logic ack, input logic a, input logic d, input logic [7:0] exp);
    @(posedge clk);
    {vector_ack_n, chip_sel_n, rd_n, chan_sel, data_ctl_sel} <= {!ack, ack, 1'h0, a, d};
    for (k = 0; k < 8 && host_data_oe_n !== 1'h0; k++) begin @(posedge clk); #1; end
    chk("rd_data", bus, exp);
    @(posedge clk);
    {vector_ack_n, chip_sel_n, rd_n} <= 3'h7;
    for (k = 0; k < 8 && host_data_oe_n !== 1'h1; k++) begin @(posedge clk); #1; end
    chk("released", host_data_oe_n, 8'h01);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {chip_sel_n, rd_n, wr_n, vector_ack_n, chain_priority_in, send_permit_a_n, send_permit_b_n} = 7'h7F;
    {carrier_present_a_n, carrier_present_b_n, clk_en} = 3'h7;
    {rst_n, chan_sel, data_ctl_sel, int_ack_done, host_en} = 5'h00;
    {host_byte, vector_value, cfg_a, cfg_b, dma_want} = {8'h00, 8'h5A, 5'h00, 5'h00, 2'h0};
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    #1 chk("rst_oe", host_data_oe_n, 8'h01);
    chk("rst_irq", irq_oe_n, 8'h01);
    chk("rst_chain", chain_priority_out, 8'h00);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) bus_wr(i[1], i[0], 8'hA0 + 8'(i));
    for (int i = 0; i < 4; i++) bus_rd(1'h0, i[1], i[0], 8'hA0 + 8'(i));
    $display("test slots done");
    s = nstb;
    {wr_n, host_en} <= 2'h1;
    repeat (6) @(posedge clk);
    {chip_sel_n, rd_n, wr_n, host_en} <= 4'h0;
    repeat (6) @(posedge clk);
    #1 chk("soft_reset", soft_reset, 8'h01);
    @(posedge clk);
    {chip_sel_n, rd_n, wr_n} <= 3'h7;
    repeat (6) @(posedge clk);
    chk("no_write", 8'(nstb - s), 8'h00);
    $display("test refusals done");
    {cfg_a, cfg_b, send_permit_a_n, carrier_present_b_n} <= {5'h12, 5'h14, 2'h0};
    repeat (6) @(posedge clk);
    #1 chk("tx_en", tx_enable, 8'h01);
    chk("rx_en", rx_enable, 8'h02);
    chk("stat_a", stat_a, 8'h0A);
    chk("stat_b", stat_b, 8'h05);
    chk("irq_on", irq_oe_n, 8'h00);
    chk("req_a", terminal_ready_or_dma_req_a, 8'h00);
    chk("req_b", terminal_ready_or_dma_req_b, 8'h01);
    // command write stores its byte in the slot and clears channel A change flags
    bus_wr(1'h1, 1'h0, 8'hA2);
    bus_rd(1'h0, 1'h1, 1'h0, 8'hA2);
    repeat (3) @(posedge clk);
    #1 chk("stat_clr", stat_a, 8'h08);
    chk("irq_off", irq_oe_n, 8'h01);
    @(posedge clk);
    {cfg_b, dma_want} <= {5'h08, 2'h2};
    repeat (3) @(posedge clk);
    #1 chk("dma_on", terminal_ready_or_dma_req_b, 8'h01);
    @(posedge clk);
    dma_want <= 2'h0;
    repeat (3) @(posedge clk);
    #1 chk("dma_off", terminal_ready_or_dma_req_b, 8'h00);
    @(posedge clk);
    {clk_en, send_permit_b_n} <= 2'h0;
    repeat (6) @(posedge clk);
    #1 chk("frozen", stat_b, 8'h05);
    @(posedge clk);
    clk_en <= 1'h1;
    repeat (6) @(posedge clk);
    #1 chk("thawed", stat_b, 8'h0F);
    $display("test modem done");
    @(posedge clk);
    send_permit_a_n <= 1'h1;
    repeat (6) @(posedge clk);
    bus_rd(1'h1, 1'h0, 1'h0, 8'h5A);
    chk("ius", under_service_flag, 8'h01);
    chk("chain_busy", chain_priority_out, 8'h00);
    chk("irq_masked", irq_oe_n, 8'h01);
    @(posedge clk);
    int_ack_done <= 1'h1;
    @(posedge clk);
    int_ack_done <= 1'h0;
    repeat (3) @(posedge clk);
    #1 chk("ius_clr", under_service_flag, 8'h00);
    chk("chain_free", chain_priority_out, 8'h01);
    chk("irq_back", irq_oe_n, 8'h00);
    @(posedge clk);
    chain_priority_in <= 1'h0;
    repeat (6) @(posedge clk);
    #1 chk("chain_blk", chain_priority_out, 8'h00);
    @(posedge clk);
    chain_priority_in <= 1'h1;
    $display("test acknowledge done");
    tally_and_finish;
  end
endmodule
